// *** inc/sbc_cfg_pkg.sv ***
// Shared constants for the configuration and physical layer register block
package sbc_cfg_pkg;

   // ----------------------------------------------------------------
   // Register indices and AHB byte addresses
   // ----------------------------------------------------------------
   localparam logic [3:0] SCF_IDX   = 4'h2;
   localparam logic [3:0] PLC_IDX   = 4'h3;
   localparam logic [7:0] XCHG_ADDR = 8'h00;
   localparam logic [7:0] STAT_ADDR = 8'h10;

   // ----------------------------------------------------------------
   // Word layout
   // ----------------------------------------------------------------
   localparam int B_SEL_HI = 15;
   localparam int B_SEL_LO = 14;
   localparam int B_RRS    = 13;
   localparam int B_NOWR   = 12;
   localparam logic [1:0] SEL_SCF = 2'h2;
   localparam logic [1:0] SEL_PLC = 2'h3;
   // System configuration fields
   localparam int B_GS     = 9;
   localparam int B_RL     = 8;
   localparam int B_AUX_HI = 7;
   localparam int B_AUX_LO = 6;
   localparam int B_UV     = 5;
   localparam int B_CM     = 4;
   localparam int B_WEN    = 3;
   localparam int B_WS     = 2;
   localparam int B_INH    = 0;
   localparam logic [1:0] AUX_OFF = 2'h0;
   localparam logic [1:0] AUX_ON  = 2'h1;
   localparam logic [1:0] AUX_C16 = 2'h2;
   localparam logic [1:0] AUX_C32 = 2'h3;
   // Physical layer fields
   localparam int B_PN    = 10;
   localparam int B_OFFT  = 9;
   localparam int B_TXDIS = 8;
   localparam int B_LOOP  = 7;
   localparam int B_SLOPE = 4;
   localparam int B_TERM  = 2;
   localparam int B_LWAKE = 1;
   localparam int B_LTX   = 0;
   // Writable masks and values after reset
   localparam logic [15:0] SCF_WMASK = 16'h03FD;
   localparam logic [15:0] PLC_WMASK = 16'h0797;
   localparam logic [15:0] SCF_RST   = 16'h0101;
   localparam logic [15:0] PLC_RST   = 16'h0000;

   // ----------------------------------------------------------------
   // Modes seen from the mode controller
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_RESET   = 3'h0;
   localparam logic [2:0] MODE_STARTUP = 3'h1;
   localparam logic [2:0] MODE_NORMAL  = 3'h2;
   localparam logic [2:0] MODE_STANDBY = 3'h3;
   localparam logic [2:0] MODE_SLEEP   = 3'h4;
   localparam logic [1:0] CAN_OFFLINE  = 2'h0;
   localparam logic [1:0] CAN_ONLINE   = 2'h1;
   localparam logic [1:0] CAN_ACTIVE   = 2'h2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ      = 40_000_000;
   localparam int US_CYC      = CLK_HZ / 1_000_000;
   localparam int US_PER_MS   = 1000;
   localparam int AUX_ON_US   = 350;
   localparam int AUX_P1_MS   = 16;
   localparam int AUX_P2_MS   = 32;
   localparam int OFF_SHRT_MS = 64;
   localparam int OFF_LONG_MS = 256;
   localparam int OFF_WAKE_MS = 400;

   // Synchroniser lanes
   localparam int SY_SHORT = 0;
   localparam int SY_RXCL  = 1;
   localparam int SY_TXCL  = 2;
   localparam int SY_TXD   = 3;
   localparam int SY_BUSRX = 4;
   localparam int SY_ACT   = 5;
   localparam int SY_WAKE  = 6;
   localparam int SY_CURR  = 7;

   typedef enum logic [2:0]
   {
      BS_IDLE = 3'b001,
      BS_WR   = 3'b010,
      BS_RD   = 3'b100
   } bus_st_t;

endpackage

// *** hw/sbc_config_phy_regs.sv ***
// System configuration and physical layer register words behind AHB-Lite
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module sbc_config_phy_regs
#(
   parameter int P_US_PER_MS = sbc_cfg_pkg::US_PER_MS
)
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_hsel,
   input  wire logic [7:0]  i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   input  wire logic [2:0]  i_sbc_mode,
   input  wire logic [1:0]  i_can_state,
   input  wire logic        i_watchdog_off,
   input  wire logic [15:0] i_gen_feedback,
   input  wire logic        i_aux_short,
   input  wire logic        i_rx_recessive_clamp,
   input  wire logic        i_tx_dominant_clamp,
   input  wire logic        i_can_transmit_line,
   input  wire logic        i_can_bus_rx,
   input  wire logic        i_can_bus_activity,
   input  wire logic        i_wake_event,
   input  wire logic        i_main_current_rise,
   output logic             o_ground_shift_level_sel,
   output logic             o_reset_pulse_length_sel,
   output logic             o_third_supply_output,
   output logic             o_main_undervolt_level_sel,
   output logic             o_local_wake_enable,
   output logic             o_local_wake_sampling_sel,
   output logic             o_inhibit_output,
   output logic             o_reset_request,
   output logic             o_watchdog_restart,
   output logic             o_partial_network_allow,
   output logic             o_can_tx_disable,
   output logic             o_can_receive_line,
   output logic             o_can_offline_req,
   output logic             o_lin_slope_sel,
   output logic             o_lin_termination_source_sel,
   output logic             o_lin_wake_enable,
   output logic             o_lin_tx_disable
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed
   {
      sbc_cfg_pkg::bus_st_t st;
      logic [7:0]           addr;
      logic [31:0]          rdata;
      logic [15:0]          sys_cfg;
      logic [15:0]          phy_ctl;
      logic [15:0]          reply;
      logic [7:0]           sy1;
      logic [7:0]           sy2;
      logic [7:0]           sy3;
      logic [1:0]           can_prev;
      logic [5:0]           us_cnt;
      logic [9:0]           ms_sub;
      logic [14:0]          aux_ph;
      logic                 aux_on;
      logic [8:0]           off_ms;
      logic                 after_wake;
      logic                 off_req;
      logic                 rst_req;
      logic                 wd_rst;
      logic                 rx_out;
   } state_t;

   localparam state_t ST_RST = '{
      st:      sbc_cfg_pkg::BS_IDLE,
      sys_cfg: sbc_cfg_pkg::SCF_RST,
      phy_ctl: sbc_cfg_pkg::PLC_RST,
      default: '0
   };

   state_t      s_r;
   state_t      s_nxt;
   logic [7:0]  pins;
   logic        acc;
   logic        wr_x;
   logic [15:0] xw;
   logic        us_tick;
   logic        ms_tick;
   logic        fault;
   logic        enter_on;
   logic        mode_ok;
   logic [8:0]  off_lim;
   logic [14:0] aux_per;

   localparam int B_HI = sbc_cfg_pkg::B_SEL_HI;
   localparam int B_LO = sbc_cfg_pkg::B_SEL_LO;

   // Byte address of a register index, one word per index
   function automatic logic [7:0] idx_addr(input logic [3:0] idx);
      idx_addr = {2'h0, idx, 2'h0};
   endfunction

   // Feedback word: select pattern on top, fourteen content bits below
   function automatic logic [15:0] fb_word(input logic [1:0] sel,
                                           input logic [15:0] v);
      fb_word = {sel, v[13:0]};
   endfunction

   // ----------------------------------------------------------------
   // Decodes
   // ----------------------------------------------------------------
   // Pins from the analog side, synchronised before use
   assign pins = {i_main_current_rise, i_wake_event, i_can_bus_activity,
                  i_can_bus_rx, i_can_transmit_line, i_tx_dominant_clamp,
                  i_rx_recessive_clamp, i_aux_short};
   assign acc  = i_hsel & i_htrans[1] & i_hready;
   // Word position fixed
   // A write to a register's own address forces its select pattern
   always_comb
   begin
      xw = i_hwdata[15:0];
      if (s_r.addr == idx_addr(sbc_cfg_pkg::SCF_IDX))
      begin
         xw[15:14] = sbc_cfg_pkg::SEL_SCF;
      end
      else if (s_r.addr == idx_addr(sbc_cfg_pkg::PLC_IDX))
      begin
         xw[15:14] = sbc_cfg_pkg::SEL_PLC;
      end
   end
   assign wr_x = (s_r.st == sbc_cfg_pkg::BS_WR) &&
                 ((s_r.addr == sbc_cfg_pkg::XCHG_ADDR) ||
                  (s_r.addr == idx_addr(sbc_cfg_pkg::SCF_IDX)) ||
                  (s_r.addr == idx_addr(sbc_cfg_pkg::PLC_IDX)));
   assign us_tick  = (s_r.us_cnt == 6'(sbc_cfg_pkg::US_CYC - 1));
   assign ms_tick  = us_tick && (s_r.ms_sub == 10'(P_US_PER_MS - 1));
   assign fault    = s_r.sy2[sbc_cfg_pkg::SY_SHORT] |
                     s_r.sy2[sbc_cfg_pkg::SY_RXCL] |
                     s_r.sy2[sbc_cfg_pkg::SY_TXCL];
   // Any change into On-line or Active counts, Active from On-line too
   assign enter_on = ((i_can_state == sbc_cfg_pkg::CAN_ONLINE) ||
                      (i_can_state == sbc_cfg_pkg::CAN_ACTIVE)) &&
                     (s_r.can_prev != i_can_state);
   assign mode_ok  = (i_sbc_mode == sbc_cfg_pkg::MODE_NORMAL) ||
                     (i_sbc_mode == sbc_cfg_pkg::MODE_STANDBY);
   assign off_lim  = s_r.after_wake ? 9'(sbc_cfg_pkg::OFF_WAKE_MS) :
                     s_r.phy_ctl[sbc_cfg_pkg::B_OFFT] ?
                     9'(sbc_cfg_pkg::OFF_LONG_MS) : 9'(sbc_cfg_pkg::OFF_SHRT_MS);
   assign aux_per  = s_r.sys_cfg[sbc_cfg_pkg::B_AUX_HI:sbc_cfg_pkg::B_AUX_LO] ==
                     sbc_cfg_pkg::AUX_C32 ?
                     15'(sbc_cfg_pkg::AUX_P2_MS * P_US_PER_MS) :
                     15'(sbc_cfg_pkg::AUX_P1_MS * P_US_PER_MS);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_nxt          = s_r;
      s_nxt.sy1      = pins;
      s_nxt.sy2      = s_r.sy1;
      s_nxt.sy3      = s_r.sy2;
      s_nxt.can_prev = i_can_state;
      s_nxt.off_req  = 1'b0;
      s_nxt.rst_req  = 1'b0;
      s_nxt.wd_rst   = 1'b0;
      // Bus phase tracking; zero wait states, so any state may take a new one
      case (s_r.st)
         sbc_cfg_pkg::BS_IDLE,
         sbc_cfg_pkg::BS_WR,
         sbc_cfg_pkg::BS_RD:
         begin
            s_nxt.st = sbc_cfg_pkg::BS_IDLE;
            if (acc)
            begin
               s_nxt.st   = i_hwrite ? sbc_cfg_pkg::BS_WR : sbc_cfg_pkg::BS_RD;
               s_nxt.addr = i_haddr;
            end
         end
         default:
         begin
            s_nxt.st = sbc_cfg_pkg::BS_IDLE;
         end
      endcase
      // Read data latched at the address phase; unmapped reads give zero
      if (acc && !i_hwrite)
      begin
         s_nxt.rdata = 32'h0000_0000;
         if (i_haddr == sbc_cfg_pkg::XCHG_ADDR)
         begin
            s_nxt.rdata = {16'h0000, s_r.reply};
         end
         else if (i_haddr == idx_addr(sbc_cfg_pkg::SCF_IDX))
         begin
            s_nxt.rdata = {16'h0000, s_r.sys_cfg};
         end
         else if (i_haddr == idx_addr(sbc_cfg_pkg::PLC_IDX))
         begin
            s_nxt.rdata = {16'h0000, s_r.phy_ctl};
         end
         else if (i_haddr == sbc_cfg_pkg::STAT_ADDR)
         begin
            s_nxt.rdata = {23'h000000, s_r.aux_on, s_r.after_wake,
                           mode_ok, 1'b0, i_can_state, i_sbc_mode};
         end
      end
      // Word exchange in the write data phase
      if (wr_x)
      begin
         case (xw[B_HI:B_LO])
            sbc_cfg_pkg::SEL_SCF:
            begin
               s_nxt.reply = fb_word(sbc_cfg_pkg::SEL_SCF, s_r.sys_cfg);
               if (!xw[sbc_cfg_pkg::B_NOWR])
               begin
                  s_nxt.sys_cfg = xw & sbc_cfg_pkg::SCF_WMASK;
               end
            end
            sbc_cfg_pkg::SEL_PLC:
            begin
               s_nxt.reply = xw[sbc_cfg_pkg::B_RRS] ?
                             fb_word(sbc_cfg_pkg::SEL_PLC, i_gen_feedback) :
                             fb_word(sbc_cfg_pkg::SEL_PLC, s_r.phy_ctl);
               if (!xw[sbc_cfg_pkg::B_NOWR] && mode_ok)
               begin
                  s_nxt.phy_ctl = xw & sbc_cfg_pkg::PLC_WMASK;
               end
            end
            default:
            begin
               s_nxt.reply = {xw[B_HI:B_LO], 14'h0000};
            end
         endcase
      end
      // Hardware updates come last so they win over a same-cycle write
      // Fail-safe inhibit
      if (i_sbc_mode == sbc_cfg_pkg::MODE_RESET)
      begin
         s_nxt.sys_cfg[sbc_cfg_pkg::B_INH] = 1'b1;
      end
      if (fault)
      begin
         s_nxt.phy_ctl[sbc_cfg_pkg::B_TXDIS] = 1'b1;
      end
      if (enter_on)
      begin
         s_nxt.phy_ctl[sbc_cfg_pkg::B_PN] = 1'b0;
      end
      if (s_r.sy2[sbc_cfg_pkg::SY_CURR] && !s_r.sy3[sbc_cfg_pkg::SY_CURR])
      begin
         if (s_r.sys_cfg[sbc_cfg_pkg::B_CM] && i_watchdog_off)
         begin
            s_nxt.rst_req = 1'b1;
         end
         else
         begin
            s_nxt.wd_rst = 1'b1;
         end
      end
      s_nxt.rx_out = (s_r.phy_ctl[sbc_cfg_pkg::B_TXDIS] &&
                      s_r.phy_ctl[sbc_cfg_pkg::B_LOOP]) ?
                     s_r.sy2[sbc_cfg_pkg::SY_TXD] : s_r.sy2[sbc_cfg_pkg::SY_BUSRX];
      // Microsecond and millisecond time base
      s_nxt.us_cnt = us_tick ? 6'h00 : s_r.us_cnt + 6'h01;
      if (us_tick)
      begin
         s_nxt.ms_sub = ms_tick ? 10'h000 : s_r.ms_sub + 10'h001;
         s_nxt.aux_ph = (s_r.aux_ph >= aux_per - 15'h0001) ? 15'h0000 :
                        s_r.aux_ph + 15'h0001;
      end
      // Auxiliary supply decode; short on-window each period in the 16 and 32 ms cyclic settings
      case (s_r.sys_cfg[sbc_cfg_pkg::B_AUX_HI:sbc_cfg_pkg::B_AUX_LO])
         sbc_cfg_pkg::AUX_ON:  s_nxt.aux_on = 1'b1;
         sbc_cfg_pkg::AUX_C16,
         sbc_cfg_pkg::AUX_C32: s_nxt.aux_on =
                               s_r.aux_ph < 15'(sbc_cfg_pkg::AUX_ON_US);
         default:              s_nxt.aux_on = 1'b0;
      endcase
      if (s_r.sy2[sbc_cfg_pkg::SY_WAKE] && !s_r.sy3[sbc_cfg_pkg::SY_WAKE])
      begin
         s_nxt.after_wake = 1'b1;
      end
      if (i_can_state != sbc_cfg_pkg::CAN_ONLINE ||
          (s_r.sy2[sbc_cfg_pkg::SY_ACT] && !s_r.sy3[sbc_cfg_pkg::SY_ACT]))
      begin
         s_nxt.off_ms = 9'h000;
      end
      else if (ms_tick)
      begin
         if (s_r.off_ms + 9'h001 >= off_lim)
         begin
            s_nxt.off_ms     = 9'h000;
            s_nxt.off_req    = 1'b1;
            s_nxt.after_wake = 1'b0;
         end
         else
         begin
            s_nxt.off_ms = s_r.off_ms + 9'h001;
         end
      end
   end

   // State register, synchronous reset
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         s_r <= ST_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Slave never stretches and never errors
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;
   assign o_hrdata    = s_r.rdata;
   assign o_ground_shift_level_sel   = s_r.sys_cfg[sbc_cfg_pkg::B_GS];
   assign o_reset_pulse_length_sel   = s_r.sys_cfg[sbc_cfg_pkg::B_RL];
   assign o_third_supply_output      = s_r.aux_on;
   assign o_main_undervolt_level_sel = s_r.sys_cfg[sbc_cfg_pkg::B_UV];
   assign o_local_wake_enable        = s_r.sys_cfg[sbc_cfg_pkg::B_WEN];
   assign o_local_wake_sampling_sel  = s_r.sys_cfg[sbc_cfg_pkg::B_WS];
   assign o_inhibit_output           = s_r.sys_cfg[sbc_cfg_pkg::B_INH];
   assign o_reset_request            = s_r.rst_req;
   assign o_watchdog_restart         = s_r.wd_rst;
   assign o_partial_network_allow    = s_r.phy_ctl[sbc_cfg_pkg::B_PN];
   assign o_can_tx_disable           = s_r.phy_ctl[sbc_cfg_pkg::B_TXDIS];
   assign o_can_receive_line         = s_r.rx_out;
   assign o_can_offline_req          = s_r.off_req;
   assign o_lin_slope_sel            = s_r.phy_ctl[sbc_cfg_pkg::B_SLOPE];
   assign o_lin_termination_source_sel = s_r.phy_ctl[sbc_cfg_pkg::B_TERM];
   assign o_lin_wake_enable          = s_r.phy_ctl[sbc_cfg_pkg::B_LWAKE];
   assign o_lin_tx_disable           = s_r.phy_ctl[sbc_cfg_pkg::B_LTX];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   AST_SCF_REPLY: assert property (wr_x && xw[B_HI:B_LO] == sbc_cfg_pkg::SEL_SCF
      |=> s_r.reply == {sbc_cfg_pkg::SEL_SCF, $past(s_r.sys_cfg[13:0])})
      else $error("config reply wrong");
   AST_SCF_KEEP: assert property (wr_x && xw[B_HI:B_LO] == sbc_cfg_pkg::SEL_SCF
      && xw[sbc_cfg_pkg::B_NOWR] && i_sbc_mode != sbc_cfg_pkg::MODE_RESET
      |=> $stable(s_r.sys_cfg))
      else $error("config changed on read-only");
   AST_SCF_STORE: assert property (wr_x && xw[B_HI:B_LO] == sbc_cfg_pkg::SEL_SCF
      && !xw[sbc_cfg_pkg::B_NOWR] && i_sbc_mode != sbc_cfg_pkg::MODE_RESET
      |=> s_r.sys_cfg == ($past(xw) & sbc_cfg_pkg::SCF_WMASK))
      else $error("config not stored");
   AST_PLC_GATE: assert property (wr_x && !mode_ok
      |=> (s_r.phy_ctl | 16'h0500) == ($past(s_r.phy_ctl) | 16'h0500))
      else $error("physical write outside allowed mode");
   AST_RRS: assert property (wr_x && xw[B_HI:B_LO] == sbc_cfg_pkg::SEL_PLC
      && xw[sbc_cfg_pkg::B_RRS]
      |=> s_r.reply == {sbc_cfg_pkg::SEL_PLC, $past(i_gen_feedback[13:0])})
      else $error("general feedback not returned");
   AST_PN_CLR: assert property (enter_on |=> !o_partial_network_allow)
      else $error("selective sleep not cleared");
   AST_TX_FAULT: assert property (fault |=> ##[0:1] o_can_tx_disable)
      else $error("transmitter not disabled on fault");
   AST_LOOP: assert property (s_r.phy_ctl[sbc_cfg_pkg::B_TXDIS] &&
      s_r.phy_ctl[sbc_cfg_pkg::B_LOOP]
      |=> o_can_receive_line == $past(s_r.sy2[sbc_cfg_pkg::SY_TXD]))
      else $error("loop-back missing");
   AST_INH: assert property (i_sbc_mode == sbc_cfg_pkg::MODE_RESET
      |=> o_inhibit_output)
      else $error("inhibit not set in reset");
   AST_AUX_OFF: assert property ((s_r.sys_cfg[7:6] == sbc_cfg_pkg::AUX_OFF) [*2]
      |-> !o_third_supply_output)
      else $error("auxiliary supply on while off");
   AST_CURR: assert property (s_r.sy2[sbc_cfg_pkg::SY_CURR] &&
      !s_r.sy3[sbc_cfg_pkg::SY_CURR] && s_r.sys_cfg[sbc_cfg_pkg::B_CM] && i_watchdog_off
      |=> o_reset_request && !o_watchdog_restart)
      else $error("current rise did not reset");

endmodule

// *** sim/host_model.sv ***
// Host model: AHB-Lite master issuing single register word transfers
`timescale 1ns/1ps
module host_model
(
   input  wire logic        i_clk,
   input  wire logic        i_hready,
   input  wire logic [31:0] i_hrdata,
   output logic      [7:0]  o_haddr  = 8'h00,
   output logic      [1:0]  o_htrans = 2'h0,
   output logic             o_hwrite = 1'b0,
   output logic      [31:0] o_hwdata = 32'h00000000,
   output logic             o_hung   = 1'b0
);
   // ----------------------------------------------------------------
   // Word transfer
   // ----------------------------------------------------------------
   // Whole word exchange
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] rd);
      int n;
      n = 0;
      o_haddr  <= a;
      o_hwrite <= wr;
      o_htrans <= 2'h2;
      @(posedge i_clk);
      while (i_hready !== 1'b1 && n < 64)
      begin
         @(posedge i_clk);
         n++;
      end
      o_htrans <= 2'h0;
      o_hwdata <= {16'h0000, d};
      @(posedge i_clk);
      while (i_hready !== 1'b1 && n < 64)
      begin
         @(posedge i_clk);
         n++;
      end
      rd = i_hrdata[15:0];
      if (n >= 64)
         o_hung = 1'b1;
      // Idle gap cycle; a reply read right after an exchange already sees the new reply
      @(posedge i_clk);
   endtask
endmodule

// *** sim/tb_top.sv ***
// Testbench: random and corner register word exchanges
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] A_SCF = {2'b00, sbc_cfg_pkg::SCF_IDX, 2'b00};
   localparam logic [7:0] A_PLC = {2'b00, sbc_cfg_pkg::PLC_IDX, 2'b00};
   localparam int         MSP   = 4;
   logic        sys_clk = 1'b0, sys_rst = 1'b1, txd = 1'b0, hung, hwrite;
   logic [2:0]  mode = sbc_cfg_pkg::MODE_NORMAL, fault = 3'h0, m;
   logic [3:0]  ev = 4'h0;
   logic [15:0] gen = 16'h0000, rd, sw, pw, e_scf = sbc_cfg_pkg::SCF_RST;
   logic [15:0] e_plc = sbc_cfg_pkg::PLC_RST;
   logic [1:0]  cs = 2'h0;
   logic        wk = 1'b0, cur = 1'b0, rr, wr, ok;
   wire         hresp, rst_w, wd_w, off_w;
   int          n;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, hrdata, w;
   wire         hready;
   wire  [15:0] cp, pp;
   int          seed = 34443, errors = 0, n_checks = 0;
   always #12.5 sys_clk = ~sys_clk;
   // Unused feedback bit positions held low
   assign {cp[15:10], cp[7:6], cp[4], cp[1]} = 10'h000;
   assign {pp[15:11], pp[9], pp[6:5], pp[3]} = 9'h000;
   host_model host (.i_clk(sys_clk), .i_hready(hready), .i_hrdata(hrdata), .o_haddr(haddr),
      .o_htrans(htrans), .o_hwrite(hwrite), .o_hwdata(hwdata), .o_hung(hung));
   sbc_config_phy_regs #(.P_US_PER_MS(MSP)) dut (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst),
      .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
      .o_hresp(hresp), .i_sbc_mode(mode), .i_can_state(cs), .i_watchdog_off(ev[0]),
      .i_gen_feedback(gen), .i_aux_short(fault[0]), .i_rx_recessive_clamp(fault[1]),
      .i_tx_dominant_clamp(fault[2]), .i_can_transmit_line(txd), .i_can_bus_rx(1'b1),
      .i_can_bus_activity(ev[1]), .i_wake_event(wk), .i_main_current_rise(cur),
      .o_ground_shift_level_sel(cp[9]), .o_reset_pulse_length_sel(cp[8]),
      .o_third_supply_output(), .o_main_undervolt_level_sel(cp[5]),
      .o_local_wake_enable(cp[3]), .o_local_wake_sampling_sel(cp[2]), .o_inhibit_output(cp[0]),
      .o_reset_request(rst_w), .o_watchdog_restart(wd_w), .o_partial_network_allow(pp[10]),
      .o_can_tx_disable(pp[8]), .o_can_receive_line(pp[7]), .o_can_offline_req(off_w),
      .o_lin_slope_sel(pp[4]), .o_lin_termination_source_sel(pp[2]),
      .o_lin_wake_enable(pp[1]), .o_lin_tx_disable(pp[0]));
   // Compare and count
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Exchange a word, then read back the reply
   task automatic xch(input logic [15:0] word, input logic [15:0] exp);
      host.xfer(1'b1, 8'h00, word, rd);
      host.xfer(1'b0, 8'h00, 16'h0000, rd);
      check("reply", rd, exp);
   endtask
   task automatic stop_test;
      if (hung === 1'b1)
         errors++;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      host.xfer(1'b0, A_SCF, 16'h0000, rd);
      check("scf reset", rd, sbc_cfg_pkg::SCF_RST);
      check("hresp", {15'h0000, hresp}, 16'h0000);
      for (int i = 0; i < 16; i++)
      begin
         w = $random(seed);
         m = (i % 4 == 3) ? sbc_cfg_pkg::MODE_SLEEP : 3'h2 + 3'(i % 2);
         mode <= m;
         gen <= w[31:16];
         ev <= {2'b00, w[1:0]};
         sw = {sbc_cfg_pkg::SEL_SCF, 1'b0, w[12], w[11:0] & sbc_cfg_pkg::SCF_WMASK[11:0]};
         pw = {sbc_cfg_pkg::SEL_PLC, w[30:29], w[27:16] & sbc_cfg_pkg::PLC_WMASK[11:0]};
         xch(sw, {sbc_cfg_pkg::SEL_SCF, e_scf[13:0]});
         if (!sw[12])
            e_scf = sw & sbc_cfg_pkg::SCF_WMASK;
         xch(pw, {sbc_cfg_pkg::SEL_PLC, pw[13] ? w[29:16] : e_plc[13:0]});
         if (!pw[12] && m != sbc_cfg_pkg::MODE_SLEEP)
            e_plc = pw & sbc_cfg_pkg::PLC_WMASK;
         host.xfer(1'b0, A_SCF, 16'h0000, rd);
         check("scf", rd, e_scf);
         host.xfer(1'b0, A_PLC, 16'h0000, rd);
         check("plc", rd, e_plc);
         check("scf pins", cp & 16'h032D, e_scf & 16'h032D);
         check("plc pins", pp & 16'h0517, e_plc & 16'h0517);
         $display("round %0d done", i);
      end
      mode <= sbc_cfg_pkg::MODE_NORMAL;
      for (int k = 0; k < 3; k++)
      begin
         host.xfer(1'b1, 8'h00, 16'hC080, rd);
         fault <= 3'h1 << k;
         txd <= k[0];
         repeat (4) @(posedge sys_clk);
         fault <= 3'h0;
         check("tx disable", {15'h0000, pp[8]}, 16'h0001);
         repeat (2) @(posedge sys_clk);
         check("loop back", {15'h0000, pp[7]}, {15'h0000, k[0]});
      end
      // Sleep permission dropped on going on-line, no activity
      ev <= 4'h1;
      host.xfer(1'b1, 8'h00, 16'hC400, rd);
      check("pn set", {15'h0000, pp[10]}, 16'h0001);
      cs <= sbc_cfg_pkg::CAN_ONLINE;
      repeat (2) @(posedge sys_clk);
      check("pn clear", {15'h0000, pp[10]}, 16'h0000);
      // Off-line request after 64 ms ticks of silence (4 us each with MSP = 4), bounded wait
      n = 0;
      while (off_w !== 1'b1 && n < 20000)
      begin
         @(posedge sys_clk);
         n++;
      end
      ok = (n >= (sbc_cfg_pkg::OFF_SHRT_MS - 1) * MSP * sbc_cfg_pkg::US_CYC) &&
           (n <= sbc_cfg_pkg::OFF_SHRT_MS * MSP * sbc_cfg_pkg::US_CYC);
      check("offline time", {15'h0000, ok}, 16'h0001);
      $display("on-line tests done");
      // Current rise: reset with watchdog off, restart otherwise
      host.xfer(1'b1, 8'h00, 16'h8010, rd);
      for (int k = 0; k < 2; k++)
      begin
         ev <= {3'h0, ~k[0]};
         cur <= 1'b1;
         rr = 1'b0;
         wr = 1'b0;
         repeat (6)
         begin
            @(posedge sys_clk);
            rr = rr | rst_w;
            wr = wr | wd_w;
         end
         cur <= 1'b0;
         check("reset req", {15'h0000, rr}, {15'h0000, ~k[0]});
         check("wd restart", {15'h0000, wr}, {15'h0000, k[0]});
         repeat (4) @(posedge sys_clk);
      end
      $display("current monitor tests done");
      host.xfer(1'b1, 8'h00, 16'h8000, rd);
      check("inhibit off", {15'h0000, cp[0]}, 16'h0000);
      mode <= sbc_cfg_pkg::MODE_RESET;
      repeat (2) @(posedge sys_clk);
      check("inhibit on", {15'h0000, cp[0]}, 16'h0001);
      $display("fault and reset tests done");
      stop_test;
   end
endmodule
